// File: design/dhis_pkg.sv
// Purpose: shared constants and types of the display host interface front end
// Assumes: host pins already synchronous to clk_sys
// Notes:   protocol codes equal the strap pair {proto_sel_a, proto_sel_b}
`default_nettype none
package dhis_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W  = 4;

  // strap pair {a,b} -> protocol
  typedef enum logic [1:0] {
    PROTO_SPI = 2'h0,
    PROTO_68  = 2'h1,
    PROTO_I2C = 2'h2,
    PROTO_80  = 2'h3
  } dhis_proto_t;

  // i2c slave states, gray along idle-addr-ack-byte-ack
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_ADDR = 3'h1,
    I2C_AACK = 3'h3,
    I2C_BYTE = 3'h2,
    I2C_BACK = 3'h6,
    I2C_IGN  = 3'h4
  } dhis_i2c_t;

  // host bus bit positions in serial modes
  localparam int unsigned PIN_SCLK    = 0;
  localparam int unsigned PIN_SERIAL_DIN    = 1;
  localparam int unsigned PIN_SDA_OUT = 2;

  // i2c control byte fields
  localparam int unsigned CTRL_CO_BIT = 7;
  localparam int unsigned CTRL_DC_BIT = 6;

  localparam logic [CNT_W-1:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [CNT_W-1:0]  CNT_ZERO      = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 4'h1;
  localparam logic [BYTE_W-1:0] BYTE_ZERO     = 8'h00;
  localparam logic [BYTE_W-1:0] OE_ALL        = 8'hFF;
  localparam logic [BYTE_W-1:0] OE_SDA        = 8'h04;
  // upper six slave address bits; value arbitrary
  localparam logic [5:0]        I2C_ADDR_HI   = 6'h2A;
endpackage
`default_nettype wire

// File: design/dhis_skid_buf.sv
// Purpose: two-entry buffer between byte capture and the byte consumer
// Assumes: single clock, synchronous active-high reset
// Notes:   outputs are flops; in_ready falls only when both entries hold words
`default_nettype none
module dhis_skid_buf #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  if (DEPTH != 2) begin : g_depth_chk
    $error("dhis_skid_buf supports DEPTH of two only");
  end
  if (WIDTH < 1) begin : g_width_chk
    $error("dhis_skid_buf needs WIDTH of at least one");
  end

  typedef struct packed {
    logic             head_v;
    logic [WIDTH-1:0] head;
    logic             tail_v;
    logic [WIDTH-1:0] tail;
  } dhis_buf_st_t;

  dhis_buf_st_t b_q;
  dhis_buf_st_t b_d;
  logic         pop;
  logic         push;

  assign pop       = b_q.head_v & out_ready;
  assign push      = in_valid & ~b_q.tail_v;
  assign in_ready  = ~b_q.tail_v;
  assign out_valid = b_q.head_v;
  assign out_data  = b_q.head;

  always_comb begin
    b_d = b_q;
    if (pop || !b_q.head_v) begin
      // head moves on: oldest word first keeps order
      b_d.head_v = b_q.tail_v | push;
      b_d.head   = b_q.tail_v ? b_q.tail : in_data;
      b_d.tail_v = b_q.tail_v & push;
      b_d.tail   = in_data;
    end else if (push) begin
      b_d.tail_v = 1'b1;
      b_d.tail   = in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end
endmodule
`default_nettype wire

// File: design/dhis_host_if.sv
// Purpose: host interface front end: strap-selected parallel, spi or i2c byte capture
// Assumes: all pins synchronous to clk_sys and sampled on each rising edge
// Notes:   received bytes leave with a data/command flag through a two-entry buffer
`default_nettype none
module dhis_host_if (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // straps and chip reset
  input  wire logic                        proto_sel_a,
  input  wire logic                        proto_sel_b,
  input  wire logic                        reset_in_n,
  // host control pins
  input  wire logic                        cs_n,
  input  wire logic                        dc_sel,
  input  wire logic                        rw_wr_n,
  input  wire logic                        en_rd_n,
  // host data bus, three signals per pin
  input  wire logic [dhis_pkg::BYTE_W-1:0] host_data_bus_in,
  output logic      [dhis_pkg::BYTE_W-1:0] host_data_bus_out,
  output logic      [dhis_pkg::BYTE_W-1:0] host_data_bus_oe,
  // byte offered on parallel reads
  input  wire logic [dhis_pkg::BYTE_W-1:0] read_byte,
  // received byte stream
  output logic                             rx_valid,
  input  wire logic                        rx_ready,
  output logic      [dhis_pkg::BYTE_W-1:0] rx_byte,
  output logic                             rx_is_data,
  // status
  output logic                             init_active,
  output logic                             rx_dropped
);
  localparam int unsigned BW = dhis_pkg::BYTE_W;

  typedef struct packed {
    dhis_pkg::dhis_proto_t          mode;
    logic                           clk_prev;
    logic                           sda_prev;
    logic                           stb_prev;
    logic [BW-1:0]                  sr;
    logic [dhis_pkg::CNT_W-1:0]     bitcnt;
    dhis_pkg::dhis_i2c_t            i2c;
    logic                           expect_ctrl;
    logic                           co;
    logic                           dc_cap;
    logic                           push_v;
    logic [BW:0]                    push_w;
    logic [BW-1:0]                  dout;
    logic [BW-1:0]                  doe;
    logic                           drop;
    logic                           init;
  } dhis_st_t;

  dhis_st_t s_q;
  dhis_st_t s_d;
  logic     int_rst;
  logic     buf_ready;
  logic     buf_valid;
  logic [BW:0] buf_word;
  logic     sclk;
  logic     serial_din;
  logic     clk_rise;
  logic     clk_fall;
  logic     i2c_start;
  logic     i2c_stop;
  logic     cs_on;

  assign int_rst   = rst | ~reset_in_n;
  assign cs_on     = ~cs_n;
  assign sclk      = host_data_bus_in[dhis_pkg::PIN_SCLK];
  assign serial_din      = host_data_bus_in[dhis_pkg::PIN_SERIAL_DIN];
  assign clk_rise  = sclk & ~s_q.clk_prev;
  assign clk_fall  = ~sclk & s_q.clk_prev;
  assign i2c_start = sclk & s_q.clk_prev & s_q.sda_prev & ~serial_din;
  assign i2c_stop  = sclk & s_q.clk_prev & ~s_q.sda_prev & serial_din;

  always_comb begin
    s_d          = s_q;
    s_d.mode     = dhis_pkg::dhis_proto_t'({proto_sel_a, proto_sel_b});
    s_d.clk_prev = sclk;
    s_d.sda_prev = serial_din;
    s_d.stb_prev = (s_q.mode == dhis_pkg::PROTO_68) ? en_rd_n : rw_wr_n;
    s_d.push_v   = 1'b0;
    s_d.drop     = s_q.push_v & ~buf_ready;
    s_d.init     = 1'b0;
    s_d.doe      = dhis_pkg::BYTE_ZERO;
    s_d.dout     = dhis_pkg::BYTE_ZERO;
    if (s_q.mode != s_d.mode) begin
      // strap change restarts the capture of a byte
      s_d.bitcnt = dhis_pkg::CNT_ZERO;
      s_d.i2c    = dhis_pkg::I2C_IDLE;
    end else begin
      case (s_q.mode)
        dhis_pkg::PROTO_68: begin
          if (cs_on && rw_wr_n) begin
            s_d.doe  = en_rd_n ? dhis_pkg::BYTE_ZERO : dhis_pkg::OE_ALL;
            s_d.dout = read_byte;
          end
          // write latched on the falling edge of the enable strobe
          if (cs_on && !rw_wr_n && s_q.stb_prev && !en_rd_n) begin
            s_d.push_v = 1'b1;
            s_d.push_w = {dc_sel, host_data_bus_in};
          end
        end
        dhis_pkg::PROTO_80: begin
          if (cs_on && !en_rd_n) begin
            s_d.doe  = dhis_pkg::OE_ALL;
            s_d.dout = read_byte;
          end
          // write begun by strobe low, byte taken as the strobe returns high
          if (cs_on && rw_wr_n && !s_q.stb_prev) begin
            s_d.push_v = 1'b1;
            s_d.push_w = {dc_sel, host_data_bus_in};
          end
        end
        dhis_pkg::PROTO_SPI: begin
          if (!cs_on) begin
            s_d.bitcnt = dhis_pkg::CNT_ZERO;
          end else if (clk_rise) begin
            s_d.sr = {s_q.sr[BW-2:0], serial_din};
            if (s_q.bitcnt == dhis_pkg::BITS_PER_BYTE - dhis_pkg::CNT_ONE) begin
              s_d.bitcnt = dhis_pkg::CNT_ZERO;
              s_d.push_v = 1'b1;
              s_d.push_w = {dc_sel, s_q.sr[BW-2:0], serial_din};
            end else begin
              s_d.bitcnt = s_q.bitcnt + dhis_pkg::CNT_ONE;
            end
          end
        end
        default: begin
          // i2c, write transfers only; reads are not acknowledged
          if (s_q.i2c == dhis_pkg::I2C_AACK || s_q.i2c == dhis_pkg::I2C_BACK) begin
            s_d.doe = dhis_pkg::OE_SDA;
          end
          if (!cs_on) begin
            s_d.i2c = dhis_pkg::I2C_IDLE;
            s_d.doe = dhis_pkg::BYTE_ZERO;
          end else if (i2c_start) begin
            s_d.i2c    = dhis_pkg::I2C_ADDR;
            s_d.bitcnt = dhis_pkg::CNT_ZERO;
          end else if (i2c_stop) begin
            s_d.i2c = dhis_pkg::I2C_IDLE;
          end else begin
            if (clk_rise && (s_q.i2c == dhis_pkg::I2C_ADDR || s_q.i2c == dhis_pkg::I2C_BYTE)
                && s_q.bitcnt != dhis_pkg::BITS_PER_BYTE) begin
              s_d.sr     = {s_q.sr[BW-2:0], serial_din};
              s_d.bitcnt = s_q.bitcnt + dhis_pkg::CNT_ONE;
            end
            if (clk_fall) begin
              case (s_q.i2c)
                dhis_pkg::I2C_ADDR: begin
                  if (s_q.bitcnt == dhis_pkg::BITS_PER_BYTE) begin
                    s_d.bitcnt = dhis_pkg::CNT_ZERO;
                    if (s_q.sr == {dhis_pkg::I2C_ADDR_HI, dc_sel, 1'b0}) begin
                      s_d.i2c         = dhis_pkg::I2C_AACK;
                      s_d.doe         = dhis_pkg::OE_SDA;
                      s_d.expect_ctrl = 1'b1;
                    end else begin
                      s_d.i2c = dhis_pkg::I2C_IGN;
                    end
                  end
                end
                dhis_pkg::I2C_AACK, dhis_pkg::I2C_BACK: begin
                  s_d.i2c = dhis_pkg::I2C_BYTE;
                  s_d.doe = dhis_pkg::BYTE_ZERO;
                end
                dhis_pkg::I2C_BYTE: begin
                  if (s_q.bitcnt == dhis_pkg::BITS_PER_BYTE) begin
                    s_d.bitcnt = dhis_pkg::CNT_ZERO;
                    s_d.i2c    = dhis_pkg::I2C_BACK;
                    s_d.doe    = dhis_pkg::OE_SDA;
                    if (s_q.expect_ctrl) begin
                      // control byte: continuation and data/command bits
                      s_d.co          = s_q.sr[dhis_pkg::CTRL_CO_BIT];
                      s_d.dc_cap      = s_q.sr[dhis_pkg::CTRL_DC_BIT];
                      s_d.expect_ctrl = 1'b0;
                    end else if (buf_ready) begin
                      s_d.push_v      = 1'b1;
                      s_d.push_w      = {s_q.dc_cap, s_q.sr};
                      s_d.expect_ctrl = s_q.co;
                    end else begin
                      // no room: refuse with a nack rather than lose the byte
                      s_d.i2c = dhis_pkg::I2C_IGN;
                      s_d.doe = dhis_pkg::BYTE_ZERO;
                    end
                  end
                end
                default: begin
                  s_d.i2c = s_q.i2c;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (int_rst) begin
      s_q      <= '0;
      s_q.init <= 1'b1;
      s_q.clk_prev <= 1'b1;
      s_q.sda_prev <= 1'b1;
      s_q.stb_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  dhis_skid_buf #(
    .WIDTH (BW + 1),
    .DEPTH (2)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst       (int_rst),
    .in_valid  (s_q.push_v),
    .in_ready  (buf_ready),
    .in_data   (s_q.push_w),
    .out_valid (buf_valid),
    .out_ready (rx_ready),
    .out_data  (buf_word)
  );

  assign rx_valid          = buf_valid;
  assign rx_byte           = buf_word[BW-1:0];
  assign rx_is_data        = buf_word[BW];
  assign host_data_bus_out = s_q.dout;
  assign host_data_bus_oe  = s_q.doe;
  assign init_active       = s_q.init;
  assign rx_dropped        = s_q.drop;
endmodule
`default_nettype wire

// File: sim/dhis_host_if_asserts.sv
// Purpose: port checks on the host interface front end
// Assumes: straps held steady a few clocks before traffic
// Notes:   bound into every dhis_host_if
`default_nettype none
module dhis_host_if_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       reset_in_n,
  // host pins
  input wire logic       proto_sel_a,
  input wire logic       proto_sel_b,
  input wire logic       cs_n,
  input wire logic       dc_sel,
  input wire logic       rw_wr_n,
  input wire logic       en_rd_n,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_oe,
  // byte stream and status
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_is_data,
  input wire logic       init_active,
  input wire logic       rx_dropped
);
  wire logic in_rst;
  assign in_rst = rst || !reset_in_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (in_rst);
  chk_reset_state:
    assert property (disable iff (1'b0) in_rst |=> init_active && !rx_valid
      && host_data_bus_oe == 8'h00) else $error("state not cleared by reset");
  chk_init_release:
    assert property (!in_rst |=> !init_active) else $error("init stuck high");
  chk_hold_stream:
    assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_byte)
      && $stable(rx_is_data)) else $error("byte changed while stalled");
  chk_cs_gate:
    assert property (cs_n [*4] ##0 !rx_valid |=> !rx_valid)
      else $error("byte taken while deselected");
  chk_write_68:
    assert property ($fell(en_rd_n) && !cs_n && !rw_wr_n && !proto_sel_a && proto_sel_b
      && !rx_valid |-> ##2 rx_valid && rx_byte == $past(host_data_bus_in, 2)
      && rx_is_data == $past(dc_sel, 2)) else $error("68 write lost");
  chk_write_80:
    assert property ($rose(rw_wr_n) && !cs_n && proto_sel_a && proto_sel_b
      && !rx_valid |-> ##2 rx_valid && rx_byte == $past(host_data_bus_in, 2)
      && rx_is_data == $past(dc_sel, 2)) else $error("80 write lost");
  chk_read_drive:
    assert property ((!cs_n && rw_wr_n && !en_rd_n && !proto_sel_a && proto_sel_b) [*3]
      |-> host_data_bus_oe == 8'hFF) else $error("read not driven");
  chk_spi_quiet:
    assert property ((!proto_sel_a && !proto_sel_b) [*3] |-> host_data_bus_oe == 8'h00)
      else $error("bus driven in spi mode");
  chk_i2c_sda_only:
    assert property ((proto_sel_a && !proto_sel_b) [*3] |-> (host_data_bus_oe & 8'hFB) == 8'h00)
      else $error("i2c drives a pin other than sda out");
  cover property (rx_dropped);
  cover property (host_data_bus_oe == 8'h04);
  cover property (rx_valid && rx_is_data);
  cover property (rx_valid && !rx_is_data);
endmodule
bind dhis_host_if dhis_host_if_chk u_chk (
  .clk_sys          (clk_sys),
  .rst              (rst),
  .reset_in_n       (reset_in_n),
  .proto_sel_a      (proto_sel_a),
  .proto_sel_b      (proto_sel_b),
  .cs_n             (cs_n),
  .dc_sel           (dc_sel),
  .rw_wr_n          (rw_wr_n),
  .en_rd_n          (en_rd_n),
  .host_data_bus_in (host_data_bus_in),
  .host_data_bus_oe (host_data_bus_oe),
  .rx_valid         (rx_valid),
  .rx_ready         (rx_ready),
  .rx_byte          (rx_byte),
  .rx_is_data       (rx_is_data),
  .init_active      (init_active),
  .rx_dropped       (rx_dropped)
);
`default_nettype wire

// File: sim/dhis_host_model.sv
// Purpose: host controller model for parallel, spi and i2c traffic
// Assumes: tasks are entered just after a rising clk_sys
// Notes:   a released parallel or spi bus shows the inverse of its last value, never a copy
`default_nettype none
module dhis_host_model (
  // clock and pin levels as the host sees them
  input  wire logic       clk_sys,
  input  wire logic [7:0] dev_out,
  // host pins
  output logic            cs_n,
  output logic            dc_sel,
  output logic            rw_wr_n,
  output logic            en_rd_n,
  output logic      [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    dc_sel = 1'b0;
    rw_wr_n = 1'b1;
    en_rd_n = 1'b1;
    bus = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr68(input logic [7:0] b, input logic d, input logic c);
    cs_n <= c;
    rw_wr_n <= 1'b0;
    dc_sel <= d;
    bus <= b;
    step(2);
    en_rd_n <= 1'b0;
    step(2);
    en_rd_n <= 1'b1;
    cs_n <= 1'b1;
    bus <= ~b;
    step(2);
  endtask
  task automatic wr80(input logic [7:0] b, input logic d);
    cs_n <= 1'b0;
    rw_wr_n <= 1'b0;
    dc_sel <= d;
    bus <= b;
    step(2);
    rw_wr_n <= 1'b1;
    step(2);
    cs_n <= 1'b1;
    bus <= ~b;
    step(2);
  endtask
  task automatic spi(input logic [7:0] b, input logic d);
    cs_n <= 1'b0;
    dc_sel <= d;
    for (int i = 7; i >= 0; i--) begin
      bus <= {6'h00, b[i], 1'b0};
      step(2);
      bus[0] <= 1'b1;
      step(2);
    end
    cs_n <= 1'b1;
    bus <= ~bus;
    step(2);
  endtask
  task automatic rd68(output logic [7:0] got);
    cs_n <= 1'b0;
    rw_wr_n <= 1'b1;
    bus <= ~bus;
    step(2);
    en_rd_n <= 1'b0;
    step(3);
    got = dev_out;
    en_rd_n <= 1'b1;
    cs_n <= 1'b1;
    step(2);
  endtask
  // sda changes with scl low or in the same step as scl falls, except in start and stop, which move sda with scl high
  task automatic i2c_pins(input logic sda, input logic scl);
    bus <= {5'h00, sda, sda, scl};
    step(2);
  endtask
  task automatic i2c_start(input logic sa0);
    cs_n <= 1'b0;
    dc_sel <= sa0;
    i2c_pins(1'b1, 1'b1);
    i2c_pins(1'b0, 1'b1);
  endtask
  // leaves scl high after the ack clock; nack is the sda level seen there
  task automatic i2c_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      i2c_pins(b[i], 1'b0);
      i2c_pins(b[i], 1'b1);
    end
    i2c_pins(1'b1, 1'b0);
    i2c_pins(1'b1, 1'b1);
    nack = dev_out[1];
  endtask
  task automatic i2c_stop;
    i2c_pins(1'b0, 1'b0);
    i2c_pins(1'b0, 1'b1);
    i2c_pins(1'b1, 1'b1);
    cs_n <= 1'b1;
    step(2);
  endtask
endmodule
`default_nettype wire

// File: sim/display_host_interface_select_tb.sv
// Purpose: self-checking bench of the host interface front end
// Assumes: one clk_sys, host pins from dhis_host_model
// Notes:   i2c sda is one wired-and line over bus bits 1 and 2, pulled high when released
`default_nettype none
module display_host_interface_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] m; logic [7:0] b; logic d; logic [7:0] eb; logic ed;} dhis_row_t;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       proto_sel_a = 1'b0;
  logic       proto_sel_b = 1'b1;
  logic       reset_in_n = 1'b1;
  logic       rx_ready = 1'b0;
  logic [7:0] read_byte = 8'hA5;
  logic       drop_seen = 1'b0;
  logic [7:0] got;
  logic       nack;
  wire logic  cs_n, dc_sel, rw_wr_n, en_rd_n, rx_valid, rx_is_data, init_active, rx_dropped;
  wire logic [7:0] host_bus, bus_in, bus_out, bus_oe, rx_byte;
  wire logic  sda_line;
  int         err_total = 0;
  int         tests_run = 0;
  dhis_row_t  rows [6] = '{'{2'h1, 8'h5A, 1'b1, 8'h5A, 1'b1}, '{2'h1, 8'hC3, 1'b0, 8'hC3, 1'b0},
    '{2'h3, 8'h00, 1'b1, 8'h00, 1'b1}, '{2'h3, 8'hFF, 1'b0, 8'hFF, 1'b0},
    '{2'h0, 8'h81, 1'b1, 8'h81, 1'b1}, '{2'h0, 8'h7E, 1'b0, 8'h7E, 1'b0}};
  always #2.5 clk_sys = ~clk_sys;
  // wire level: device bits win where enabled; i2c ties bits 1 and 2 into one open-drain sda
  assign sda_line = host_bus[1] & ~(bus_oe[2] & ~bus_out[2]);
  assign bus_in   = (proto_sel_a && !proto_sel_b)
                  ? {host_bus[7:3], sda_line, sda_line, host_bus[0]}
                  : (bus_oe & bus_out) | (~bus_oe & host_bus);
  always @(negedge clk_sys) if (rx_dropped === 1'b1) drop_seen = 1'b1;
  dhis_host_if u_dhis_host_if (.clk_sys, .rst, .proto_sel_a, .proto_sel_b, .reset_in_n,
    .cs_n, .dc_sel, .rw_wr_n, .en_rd_n, .host_data_bus_in(bus_in),
    .host_data_bus_out(bus_out), .host_data_bus_oe(bus_oe), .read_byte, .rx_valid,
    .rx_ready, .rx_byte, .rx_is_data, .init_active, .rx_dropped);
  dhis_host_model u_dhis_host_model (.clk_sys, .dev_out(bus_in), .cs_n, .dc_sel,
    .rw_wr_n, .en_rd_n, .bus(host_bus));
  task automatic cmp_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait, a hang ends the run
  task automatic wait_valid;
    @(negedge clk_sys);
    for (int i = 0; i < 40 && rx_valid !== 1'b1; i++) @(negedge clk_sys);
    if (rx_valid !== 1'b1) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task automatic pop;
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
  endtask
  task automatic mode(input logic [1:0] m);
    {proto_sel_a, proto_sel_b} <= m;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic send(input logic [1:0] m, input logic [7:0] b, input logic d);
    case (m)
      2'h0: u_dhis_host_model.spi(b, d);
      2'h1: u_dhis_host_model.wr68(b, d, 1'b0);
      default: u_dhis_host_model.wr80(b, d);
    endcase
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp_bit("init_active", 1'b1, init_active);
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp_bit("init_active", 1'b0, init_active);
    @(posedge clk_sys);
    foreach (rows[k]) begin
      mode(rows[k].m);
      send(rows[k].m, rows[k].b, rows[k].d);
      wait_valid;
      cmp_byte("rx_byte", rows[k].eb, rx_byte);
      cmp_bit("rx_is_data", rows[k].ed, rx_is_data);
      pop;
    end
    mode(2'h1);
    u_dhis_host_model.wr68(8'h11, 1'b1, 1'b1);
    @(negedge clk_sys);
    cmp_bit("rx_valid", 1'b0, rx_valid);
    @(posedge clk_sys);
    u_dhis_host_model.rd68(got);
    cmp_byte("read drive", 8'hA5, got);
    // same pin sequence is an 80-style read: write strobe idle high, read strobe low
    mode(2'h3);
    u_dhis_host_model.rd68(got);
    cmp_byte("read drive 80", 8'hA5, got);
    mode(2'h1);
    // stalled consumer: third byte finds both entries full
    for (int j = 1; j < 4; j++) send(2'h1, j[7:0], 1'b1);
    cmp_bit("rx_dropped", 1'b1, drop_seen);
    for (int j = 1; j < 3; j++) begin
      wait_valid;
      cmp_byte("rx_byte", j[7:0], rx_byte);
      pop;
    end
    @(negedge clk_sys);
    cmp_bit("rx_valid", 1'b0, rx_valid);
    @(posedge clk_sys);
    send(2'h1, 8'h44, 1'b0);
    reset_in_n <= 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp_bit("init_active", 1'b1, init_active);
    cmp_bit("rx_valid", 1'b0, rx_valid);
    @(posedge clk_sys);
    reset_in_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    mode(2'h2);
    u_dhis_host_model.i2c_start(1'b1);
    u_dhis_host_model.i2c_byte({dhis_pkg::I2C_ADDR_HI, 1'b1, 1'b0}, nack);
    cmp_bit("address ack", 1'b0, nack);
    // control byte: continuation clear, display data
    u_dhis_host_model.i2c_byte(8'h40, nack);
    cmp_bit("control ack", 1'b0, nack);
    u_dhis_host_model.i2c_byte(8'h3C, nack);
    cmp_bit("data ack", 1'b0, nack);
    u_dhis_host_model.i2c_stop;
    wait_valid;
    cmp_byte("rx_byte", 8'h3C, rx_byte);
    cmp_bit("rx_is_data", 1'b1, rx_is_data);
    pop;
    // address low bit disagrees with the pin now: no ack, nothing taken
    u_dhis_host_model.i2c_start(1'b0);
    u_dhis_host_model.i2c_byte({dhis_pkg::I2C_ADDR_HI, 1'b1, 1'b0}, nack);
    cmp_bit("address nack", 1'b1, nack);
    u_dhis_host_model.i2c_stop;
    @(negedge clk_sys);
    cmp_bit("rx_valid", 1'b0, rx_valid);
    tally_and_finish;
  end
endmodule
`default_nettype wire
